/* common/csfr_pkg.sv */
// csfr_pkg: constants and types for the core special function register bank.
// assumes a cpu core that drives a direct-address register port on clk_sys_in.
// Behaviour
// (R1) registers reachable in 80h-FFh, direct addressing only
// (R2) bit access only where address ends 0/8
// (R3) software ignores reserved bit and location content
// (R4) port0 direction resets ones; zero means open-drain
// (R5) stack pointer resets to 07h, tracks top
// (R6) select bit one picks alternate pointer pair
// (R7) select bits one through seven read zero
// (R8) alternate pointer bytes act as plain storage
// (R9) idle wake skips vector when wake type set
// (R10) two user flags, read/write, no hardware effect
// (R11) power-down stops clocks; external or ring wakes
// (R12) idle gates cpu clock; timers, interrupts run
// (R13) overflow flag set by overflow, cleared on service
// (R14) software sets run bit to start timer
// (R15) external flag: edge cleared on vector, level follows
// (R16) trigger type: one falling edge, zero low level
// (R17) mode register: high nibble timer1, low timer0
// (R18) gate set: count only while pin high and run
// (R19) counter select: clear internal ticks, set pin edges
// (R20) mode field: 13-bit, 16-bit, 8-bit reload, reserved
// (R21) idle and power-down bits cleared on exit
// (R22) all registers load initial values at reset
package csfr_pkg;
	// register addresses
	localparam logic [7:0] ADDR_PORT0_DATA   = 8'h80;
	localparam logic [7:0] ADDR_STACK_PTR    = 8'h81;
	localparam logic [7:0] ADDR_DATA_POINTER_LOW     = 8'h82;
	localparam logic [7:0] ADDR_DATA_POINTER_HIGH    = 8'h83;
	localparam logic [7:0] ADDR_ALT_LOW      = 8'h84;
	localparam logic [7:0] ADDR_ALT_HIGH     = 8'h85;
	localparam logic [7:0] ADDR_PTR_SELECT   = 8'h86;
	localparam logic [7:0] ADDR_POWER_CTRL   = 8'h87;
	localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE   = 8'h89;
	localparam logic [7:0] ADDR_PORT0_DIR    = 8'h94;
	// reset values
	localparam logic [7:0] RST_PORT0_DATA    = 8'hFF;
	localparam logic [7:0] RST_PORT0_DIR     = 8'hFF;
	localparam logic [7:0] RST_STACK_PTR     = 8'h07;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	// bit-addressable registers have these low address bits
	localparam logic [2:0] BIT_ADDR_LOW      = 3'h0;
	// pointer select field
	localparam int         PSEL_BIT          = 0;
	// power control fields
	localparam int         PC_IDLE_WAKE_TYPE = 4;
	localparam int         PC_USER_FLAG_HIGH = 3;
	localparam int         PC_USER_FLAG_LOW  = 2;
	localparam int         PC_POWER_DOWN     = 1;
	localparam int         PC_IDLE           = 0;
	localparam logic [7:0] PC_IMPL_MASK      = 8'h1F;
	// timer control fields
	localparam int         TC_T1_OVF         = 7;
	localparam int         TC_T1_RUN         = 6;
	localparam int         TC_T0_OVF         = 5;
	localparam int         TC_T0_RUN         = 4;
	localparam int         TC_X1_FLAG        = 3;
	localparam int         TC_X1_TYPE        = 2;
	localparam int         TC_X0_FLAG        = 1;
	localparam int         TC_X0_TYPE        = 0;
	// timer mode nibble layout (same in each half)
	localparam int         TM_T1_BASE        = 4;
	localparam int         TM_T0_BASE        = 0;
	localparam int         TM_GATE           = 3;
	localparam int         TM_CT_SEL         = 2;
	localparam int         TM_MODE_HIGH      = 1;
	localparam int         TM_MODE_LOW       = 0;
	// timer mode field encodings
	localparam logic [1:0] TMODE_13BIT       = 2'h0;
	localparam logic [1:0] TMODE_16BIT       = 2'h1;
	localparam logic [1:0] TMODE_8BIT_RELOAD = 2'h2;
	localparam logic [1:0] TMODE_RESERVED    = 2'h3;
	// power state
	typedef enum logic [1:0] {
		CSFR_PM_RUN  = 2'b00,
		CSFR_PM_IDLE = 2'b01,
		CSFR_PM_DOWN = 2'b10
	} csfr_pm_t;
endpackage : csfr_pkg

/* design/csfr_bank.sv */
// csfr_bank: core special function register bank with port0, pointers, power and timer control.
// assumes the cpu core issues one direct or bit access per cycle, synchronous to clk_sys_in.
`timescale 1ns/1ps
module csfr_bank (
	input  wire logic                 clk_sys_in,            // system clock, 250 MHz
	input  wire logic                 rst_n_in,              // async reset, active low
	input  wire logic [7:0]           sfr_addr_in,           // direct address
	input  wire logic                 sfr_indirect_in,       // access uses indirect addressing
	input  wire logic                 sfr_wr_in,             // byte write strobe
	input  wire logic                 sfr_bit_wr_in,         // single-bit write strobe
	input  wire logic [2:0]           sfr_bit_sel_in,        // bit index for bit access
	input  wire logic                 sfr_bit_val_in,        // bit value for bit write
	input  wire logic [7:0]           sfr_wdata_in,          // byte write data
	output logic      [7:0]           sfr_rdata_out,         // read data, combinational
	output logic                      sfr_hit_out,           // address maps to a register here
	output logic                      sfr_bit_ok_out,        // bit access allowed at this address
	input  wire logic                 sp_wr_in,              // core updates stack pointer
	input  wire logic [7:0]           sp_wdata_in,           // new stack top
	output logic      [7:0]           sp_out,                // current stack top
	input  wire logic                 data_pointer_wr_in,            // core updates active pointer
	input  wire logic [15:0]          data_pointer_wdata_in,         // new pointer value
	output logic      [15:0]          data_pointer_out,      // active data pointer
	input  wire logic [7:0]           p0_pin_in,             // port0 pin levels
	output logic      [7:0]           p0_pin_out,            // port0 drive level, always low
	output logic      [7:0]           p0_pin_oe_out,         // port0 pull-down enable
	input  wire logic                 irq_pending_in,        // any enabled interrupt pending
	input  wire logic [1:0]           ext_int23_in,          // external interrupt 2/3 events
	input  wire logic                 ring_detect_in,        // caller ident unit ring interrupt
	output csfr_pkg::csfr_pm_t        power_state_out,       // run, idle or power-down
	output logic                      cpu_clk_en_out,        // cpu core clock enable
	output logic                      periph_clk_en_out,     // timer and interrupt clock enable
	output logic                      wake_pulse_out,        // low-power exit, one cycle
	output logic                      wake_skip_vector_out,  // exit without vectoring, one cycle
	input  wire logic [1:0]           timer_ovf_in,          // timer overflow pulses
	input  wire logic [1:0]           timer_ack_in,          // timer interrupt serviced
	input  wire logic [1:0]           ext_int_pin_in,        // external interrupt 0/1 pins
	input  wire logic [1:0]           ext_ack_in,            // external interrupt vectored
	input  wire logic [1:0]           timer_pin_in,          // timer external count pins
	input  wire logic [1:0]           int_tick_in,           // internal timer tick
	output logic      [1:0]           timer_tick_out,        // count pulse per timer
	output logic      [3:0]           timer_mode_out,        // {t1 mode, t0 mode}
	output logic      [1:0]           timer_mode_bad_out,    // reserved mode selected
	output logic      [1:0]           ext_flag_out           // external 0/1 detect flags
);
	import csfr_pkg::*;

	logic [7:0] p0_data_q;       // port0 latch
	logic [7:0] p0_dir_q;        // port0 direction, one is input
	logic [7:0] sp_q;            // stack pointer
	logic [7:0] dpl_q;           // primary pointer low
	logic [7:0] dph_q;           // primary pointer high
	logic [7:0] adpl_q;          // alternate pointer low
	logic [7:0] adph_q;          // alternate pointer high
	logic       psel_q;          // pointer select bit
	logic [4:0] power_control_q;          // power control implemented bits
	logic [7:0] timer_control_q;          // timer control
	logic [7:0] timer_mode_q;          // timer mode
	logic [1:0] xpin_q;          // previous external pin level
	logic [1:0] tpin_q;          // previous timer pin level
	logic       wake_q;          // registered wake pulse
	logic       wskip_q;         // registered skip-vector pulse
	logic       acc_ok;          // direct access in range
	logic       bit_ok;          // bit access legal here
	logic       any_wr;          // write of either kind accepted
	logic [7:0] wmask;           // bits touched by write
	logic [7:0] wval;            // value of touched bits
	logic [7:0] timer_control_d;          // next timer control
	logic [7:0] power_control_wr;         // power control with a software write merged in
	logic [1:0] xfall;           // falling edge on external pins
	logic [1:0] count_en;        // timer counting enabled
	logic       idle_exit;       // idle ends this cycle
	logic       down_exit;       // power-down ends this cycle

	// only direct accesses to the upper half reach the bank
	assign acc_ok = !sfr_indirect_in && sfr_addr_in[7]; // [R1]
	// bit access only at addresses whose low hex digit is 0 or 8
	assign bit_ok = acc_ok && (sfr_addr_in[2:0] == BIT_ADDR_LOW); // [R2]
	assign any_wr = acc_ok && (sfr_wr_in || (sfr_bit_wr_in && bit_ok)); // [R2]
	assign sfr_bit_ok_out = bit_ok;

	// byte write touches all bits, bit write only the selected one
	always_comb begin
		if (sfr_bit_wr_in && !sfr_wr_in) begin
			wmask = 8'h01 << sfr_bit_sel_in;
			wval  = {8{sfr_bit_val_in}};
		end else begin
			wmask = 8'hFF;
			wval  = sfr_wdata_in;
		end
	end

	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] m, input logic [7:0] v);
		merge = (old_v & ~m) | (v & m);
	endfunction : merge

	// merged write value, widened so the reserved upper bits drop out cleanly
	assign power_control_wr = merge({3'h0, power_control_q}, wmask, wval);

	// port0 latch and direction
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			p0_data_q <= RST_PORT0_DATA; // [R22]
			p0_dir_q  <= RST_PORT0_DIR;  // [R4]
		end else if (any_wr) begin
			if (sfr_addr_in == ADDR_PORT0_DATA) begin
				p0_data_q <= merge(p0_data_q, wmask, wval);
			end
			if (sfr_addr_in == ADDR_PORT0_DIR) begin
				p0_dir_q <= sfr_wdata_in;
			end
		end
	end
	// open drain: pull low only where output and latch is zero
	assign p0_pin_out    = 8'h00;
	assign p0_pin_oe_out = ~p0_dir_q & ~p0_data_q; // [R4]

	// stack pointer, software write wins over core update
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sp_q <= RST_STACK_PTR; // [R5]
		end else if (any_wr && sfr_addr_in == ADDR_STACK_PTR) begin
			sp_q <= wval;
		end else if (sp_wr_in) begin
			sp_q <= sp_wdata_in; // [R5]
		end
	end
	assign sp_out = sp_q;

	// pointer pairs and select bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dpl_q  <= RST_ZERO; // [R22]
			dph_q  <= RST_ZERO;
			adpl_q <= RST_ZERO;
			adph_q <= RST_ZERO;
			psel_q <= 1'b0;
		end else if (any_wr) begin
			unique case (sfr_addr_in)
				ADDR_DATA_POINTER_LOW:   dpl_q  <= wval;
				ADDR_DATA_POINTER_HIGH:  dph_q  <= wval;
				ADDR_ALT_LOW:    adpl_q <= wval; // [R8]
				ADDR_ALT_HIGH:   adph_q <= wval; // [R8]
				ADDR_PTR_SELECT: psel_q <= wval[PSEL_BIT];
				default: begin
				end
			endcase
		end else if (data_pointer_wr_in) begin
			// core update goes to the selected pair
			if (psel_q) begin // [R6]
				{adph_q, adpl_q} <= data_pointer_wdata_in;
			end else begin
				{dph_q, dpl_q} <= data_pointer_wdata_in;
			end
		end
	end
	assign data_pointer_out = psel_q ? {adph_q, adpl_q} : {dph_q, dpl_q}; // [R6]

	// low-power exits
	assign idle_exit = power_control_q[PC_IDLE] && !power_control_q[PC_POWER_DOWN] && irq_pending_in;
	assign down_exit = power_control_q[PC_POWER_DOWN] && (xfall[0] || xfall[1] || !ext_int_pin_in[0]
		|| !ext_int_pin_in[1] || (|ext_int23_in) || ring_detect_in); // [R11]

	// power control, exit clears the request bits
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_control_q <= RST_ZERO[4:0]; // [R22]
		end else if (down_exit) begin
			power_control_q[PC_POWER_DOWN] <= 1'b0; // [R21]
			power_control_q[PC_IDLE]       <= 1'b0;
		end else if (idle_exit) begin
			power_control_q[PC_IDLE] <= 1'b0; // [R21]
		end else if (any_wr && sfr_addr_in == ADDR_POWER_CTRL) begin
			power_control_q <= power_control_wr[4:0]; // [R10]
		end
	end

	// wake pulses
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_q  <= 1'b0;
			wskip_q <= 1'b0;
		end else begin
			wake_q  <= idle_exit || down_exit;
			wskip_q <= idle_exit && power_control_q[PC_IDLE_WAKE_TYPE]; // [R9]
		end
	end
	assign wake_pulse_out       = wake_q;
	assign wake_skip_vector_out = wskip_q;

	// power state and clock enables
	always_comb begin
		if (power_control_q[PC_POWER_DOWN]) begin
			power_state_out = CSFR_PM_DOWN;
		end else if (power_control_q[PC_IDLE]) begin
			power_state_out = CSFR_PM_IDLE;
		end else begin
			power_state_out = CSFR_PM_RUN;
		end
	end
	assign cpu_clk_en_out    = (power_state_out == CSFR_PM_RUN);  // [R12]
	assign periph_clk_en_out = (power_state_out != CSFR_PM_DOWN); // [R11] [R12]

	// pin history for edge detection
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xpin_q <= 2'h3;
			tpin_q <= 2'h3;
		end else begin
			xpin_q <= ext_int_pin_in;
			tpin_q <= timer_pin_in;
		end
	end
	assign xfall = xpin_q & ~ext_int_pin_in;

	// timer control next value: software first, hardware events win
	always_comb begin
		timer_control_d = timer_control_q;
		if (any_wr && sfr_addr_in == ADDR_TIMER_CTRL) begin
			timer_control_d = merge(timer_control_q, wmask, wval); // [R14]
		end
		if (timer_ack_in[0]) begin
			timer_control_d[TC_T0_OVF] = 1'b0; // [R13]
		end
		if (timer_ack_in[1]) begin
			timer_control_d[TC_T1_OVF] = 1'b0;
		end
		if (timer_ovf_in[0]) begin
			timer_control_d[TC_T0_OVF] = 1'b1; // [R13]
		end
		if (timer_ovf_in[1]) begin
			timer_control_d[TC_T1_OVF] = 1'b1;
		end
		// edge mode: set on falling edge, cleared on vector
		if (timer_control_q[TC_X0_TYPE]) begin // [R16]
			if (ext_ack_in[0]) begin
				timer_control_d[TC_X0_FLAG] = 1'b0; // [R15]
			end
			if (xfall[0]) begin
				timer_control_d[TC_X0_FLAG] = 1'b1; // [R15]
			end
		end else begin
			timer_control_d[TC_X0_FLAG] = !ext_int_pin_in[0]; // [R15] [R16]
		end
		if (timer_control_q[TC_X1_TYPE]) begin
			if (ext_ack_in[1]) begin
				timer_control_d[TC_X1_FLAG] = 1'b0;
			end
			if (xfall[1]) begin
				timer_control_d[TC_X1_FLAG] = 1'b1;
			end
		end else begin
			timer_control_d[TC_X1_FLAG] = !ext_int_pin_in[1];
		end
	end

	// timer control and mode registers
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_control_q <= RST_ZERO; // [R22]
			timer_mode_q <= RST_ZERO;
		end else begin
			timer_control_q <= timer_control_d;
			if (any_wr && sfr_addr_in == ADDR_TIMER_MODE) begin
				timer_mode_q <= sfr_wdata_in;
			end
		end
	end
	assign ext_flag_out = {timer_control_q[TC_X1_FLAG], timer_control_q[TC_X0_FLAG]};

	// per-timer gating, source select and mode decode
	for (genvar t = 0; t < 2; t++) begin : g_timer
		localparam int BASE = (t == 0) ? TM_T0_BASE : TM_T1_BASE; // [R17]
		localparam int RUNB = (t == 0) ? TC_T0_RUN : TC_T1_RUN;
		logic [1:0] mode;
		assign mode = timer_mode_q[BASE+TM_MODE_HIGH -: 2];
		assign count_en[t] = timer_control_q[RUNB] && (!timer_mode_q[BASE+TM_GATE] || ext_int_pin_in[t]); // [R18]
		assign timer_tick_out[t] = count_en[t] && (timer_mode_q[BASE+TM_CT_SEL] ?
			(tpin_q[t] && !timer_pin_in[t]) : int_tick_in[t]); // [R19]
		assign timer_mode_out[2*t +: 2] = mode;
		assign timer_mode_bad_out[t] = (mode == TMODE_RESERVED); // [R20]
	end

	// read mux; reserved bits read zero, software must not depend on them
	always_comb begin
		sfr_hit_out   = acc_ok;
		sfr_rdata_out = 8'h00;
		if (acc_ok) begin
			unique case (sfr_addr_in)
				ADDR_PORT0_DATA: sfr_rdata_out = (p0_pin_in & p0_dir_q) | (p0_data_q & ~p0_dir_q);
				ADDR_STACK_PTR:  sfr_rdata_out = sp_q;
				ADDR_DATA_POINTER_LOW:   sfr_rdata_out = dpl_q;
				ADDR_DATA_POINTER_HIGH:  sfr_rdata_out = dph_q;
				ADDR_ALT_LOW:    sfr_rdata_out = adpl_q;
				ADDR_ALT_HIGH:   sfr_rdata_out = adph_q;
				ADDR_PTR_SELECT: sfr_rdata_out = {7'h00, psel_q}; // [R7]
				ADDR_POWER_CTRL: sfr_rdata_out = {3'h0, power_control_q} & PC_IMPL_MASK;
				ADDR_TIMER_CTRL: sfr_rdata_out = timer_control_q;
				ADDR_TIMER_MODE: sfr_rdata_out = timer_mode_q;
				ADDR_PORT0_DIR:  sfr_rdata_out = p0_dir_q;
				default: begin
					sfr_hit_out   = 1'b0; // [R3]
					sfr_rdata_out = 8'h00;
				end
			endcase
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_idle_wake;
		power_control_q[PC_IDLE] && !power_control_q[PC_POWER_DOWN] && irq_pending_in;
	endsequence
	sequence s_exit_done;
		wake_pulse_out && !power_control_q[PC_IDLE];
	endsequence

	indirect_no_write_a: assert property (sfr_indirect_in |=> $stable(timer_mode_q) && ($stable(sp_q) || $past(sp_wr_in)))
		else $error("indirect access changed a register"); // [R1]
	bit_write_legal_a: assert property (sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in == ADDR_STACK_PTR
		&& !sp_wr_in |=> $stable(sp_q)) else $error("bit write reached a byte-only register"); // [R2]
	sp_reset_value_a: assert property ($rose(rst_n_in) |-> sp_q == RST_STACK_PTR)
		else $error("stack pointer not 07h after reset"); // [R5]
	data_pointer_select_a: assert property (psel_q |-> data_pointer_out == {adph_q, adpl_q})
		else $error("alternate pair not selected"); // [R6]
	psel_read_zero_a: assert property (acc_ok && sfr_addr_in == ADDR_PTR_SELECT |-> sfr_rdata_out[7:1] == 7'h00)
		else $error("pointer select reserved bits nonzero"); // [R7]
	idle_wake_skip_a: assert property (s_idle_wake |=> s_exit_done
		and (wake_skip_vector_out == $past(power_control_q[PC_IDLE_WAKE_TYPE])))
		else $error("idle wake type not honoured"); // [R9] [R21]
	idle_clock_gate_a: assert property (power_control_q[PC_IDLE] && !power_control_q[PC_POWER_DOWN] |-> !cpu_clk_en_out && periph_clk_en_out)
		else $error("idle clock gating wrong"); // [R12]
	down_exit_a: assert property (power_control_q[PC_POWER_DOWN] && ring_detect_in |=> !power_control_q[PC_POWER_DOWN] && wake_pulse_out)
		else $error("power-down not released by ring"); // [R11] [R21]
	ovf_set_a: assert property (timer_ovf_in[0] |=> timer_control_q[TC_T0_OVF])
		else $error("overflow lost"); // [R13]
	level_follow_a: assert property (!timer_control_q[TC_X0_TYPE] |=> timer_control_q[TC_X0_FLAG] == !$past(ext_int_pin_in[0]))
		else $error("level flag does not follow pin"); // [R15] [R16]
	gate_count_a: assert property (timer_mode_q[TM_T0_BASE+TM_GATE] && !ext_int_pin_in[0] |-> !timer_tick_out[0])
		else $error("gated timer counted with pin low"); // [R18]
	mode_split_a: assert property (timer_mode_out == {timer_mode_q[5:4], timer_mode_q[1:0]})
		else $error("mode nibble split wrong"); // [R17] [R20]
endmodule : csfr_bank

/* tb/csfr_core_model.sv */
// csfr_core_model: behavioural cpu core issuing direct register accesses.
// assumes the bank takes a write on the rising edge of clk_sys_in.
`timescale 1ns/1ps
module csfr_core_model (
	input  wire logic       clk_sys_in,   // system clock
	input  wire logic [7:0] rdata_in,     // bank read data
	output logic      [7:0] addr_out,     // direct address
	output logic            indirect_out, // indirect access flag
	output logic            wr_out,       // byte write strobe
	output logic            bit_wr_out,   // bit write strobe
	output logic      [2:0] bit_sel_out,  // bit index
	output logic            bit_val_out,  // bit value
	output logic      [7:0] wdata_out     // byte data
);
	// idle bus at time zero
	initial begin
		{addr_out, indirect_out, wr_out, bit_wr_out, bit_sel_out, bit_val_out, wdata_out} = '0;
	end
	// byte write: raised at a falling edge, dropped after the rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_sys_in);
		wr_out <= 1'b0;
		addr_out <= ~a;  // released lines stop showing the old value
		wdata_out <= ~d;
	endtask : wr
	// bit write, same timing as a byte write
	task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
		@(negedge clk_sys_in);
		addr_out = a;
		bit_sel_out = s;
		bit_val_out = v;
		bit_wr_out = 1'b1;
		@(posedge clk_sys_in);
		bit_wr_out <= 1'b0;
		bit_val_out <= ~v;
	endtask : bwr
	// read: address held, data taken once settled
	task automatic rd(input logic [7:0] a, input logic ind, output logic [7:0] d);
		@(negedge clk_sys_in);
		addr_out = a;
		indirect_out = ind;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : csfr_core_model

/* tb/tb_top.sv */
// tb_top: self-checking bench for the register bank.
// assumes the core model drives the register port; bench drives the rest.
`timescale 1ns/1ps
module tb_top;
	import csfr_pkg::*;
	logic        clk_sys_in, rst_n_in, ind, wr, bw, bv, hit, bok, spw, dpw, irq, ring, wake, skip, cen, pen;
	logic [7:0]  a, wd, rd, spd, pin, oe, drv, sp, d, t;
	logic [2:0]  bs;
	logic [15:0] dpd, dp;
	logic [1:0]  i23, ovf, tack, xp, xack, tp, tki, tk, mbad, xf;
	logic [3:0]  tm;
	logic [7:0]  v [4];    // pointer bytes written
	csfr_pm_t    ps;
	int          bad_count, n_tests, n;
	csfr_core_model i_core (.clk_sys_in(clk_sys_in), .rdata_in(rd), .addr_out(a), .indirect_out(ind), .wr_out(wr),
		.bit_wr_out(bw), .bit_sel_out(bs), .bit_val_out(bv), .wdata_out(wd));
	csfr_bank i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sfr_addr_in(a), .sfr_indirect_in(ind),
		.sfr_wr_in(wr), .sfr_bit_wr_in(bw), .sfr_bit_sel_in(bs), .sfr_bit_val_in(bv), .sfr_wdata_in(wd),
		.sfr_rdata_out(rd), .sfr_hit_out(hit), .sfr_bit_ok_out(bok), .sp_wr_in(spw), .sp_wdata_in(spd), .sp_out(sp),
		.data_pointer_wr_in(dpw), .data_pointer_wdata_in(dpd), .data_pointer_out(dp), .p0_pin_in(pin), .p0_pin_out(drv),
		.p0_pin_oe_out(oe), .irq_pending_in(irq), .ext_int23_in(i23), .ring_detect_in(ring), .power_state_out(ps),
		.cpu_clk_en_out(cen), .periph_clk_en_out(pen), .wake_pulse_out(wake), .wake_skip_vector_out(skip),
		.timer_ovf_in(ovf), .timer_ack_in(tack), .ext_int_pin_in(xp), .ext_ack_in(xack), .timer_pin_in(tp),
		.int_tick_in(tki), .timer_tick_out(tk), .timer_mode_out(tm), .timer_mode_bad_out(mbad), .ext_flag_out(xf));
	// 250 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_in);
	endtask : cyc
	// port0 read: pin where input, latch where output
	function automatic logic [7:0] p0_exp(logic [7:0] p, logic [7:0] dir, logic [7:0] lat);
		return (p & dir) | (lat & ~dir);
	endfunction : p0_exp
	// gated count enable
	function automatic logic tk_exp(logic gate, logic run, logic p);
		return run & (~gate | p);
	endfunction : tk_exp
	// watchdog well beyond the expected run
	initial begin
		#80000;
		bad_count++;
		close_out();
	end
	// main sequence
	initial begin
		{rst_n_in, spw, spd, dpw, dpd, irq, i23, ring, ovf, tack, xack, tki} = '0;
		xp = 2'h3;
		tp = 2'h3;
		void'($urandom(43873));
		pin = $urandom;
		cyc(6);
		rst_n_in = 1'b1;
		i_core.rd(8'h80, 1'b0, d);
		chk(d, pin);
		for (int i = 1; i < 10; i++) begin
			i_core.rd(8'h80 + 8'(i), 1'b0, d);
			chk(d, (i == 1) ? 8'h07 : 8'h00);
		end
		i_core.rd(ADDR_PORT0_DIR, 1'b0, d);
		chk({d, oe, sp, drv}, {8'hFF, 8'h00, 8'h07, 8'h00});
		// low, indirect and unmapped accesses
		i_core.rd(8'h7F, 1'b0, d);
		chk({hit, d}, 9'h0);
		i_core.rd(8'h81, 1'b1, d);
		chk({hit, d}, 9'h0);
		i_core.rd(8'h81, 1'b0, d);
		chk(hit, 1'b1);
		i_core.rd(8'h8A, 1'b0, d);
		chk({hit, d}, 9'h0);
		// core stack update
		t = $urandom;
		@(negedge clk_sys_in);
		{spw, spd} = {1'b1, t};
		@(negedge clk_sys_in);
		spw = 1'b0;
		#1;
		chk(sp, t);
		// pointer select and both pairs
		i_core.wr(ADDR_PTR_SELECT, 8'hFF);
		i_core.rd(ADDR_PTR_SELECT, 1'b0, d);
		chk(d, 8'h01);
		for (int i = 0; i < 4; i++) begin
			v[i] = $urandom;
			i_core.wr(ADDR_DATA_POINTER_LOW + 8'(i), v[i]);
		end
		for (int s = 0; s < 2; s++) begin
			i_core.wr(ADDR_PTR_SELECT, 8'(s));
			cyc(1);
			#1;
			chk(dp, s ? {v[3], v[2]} : {v[1], v[0]});
			dpd = $urandom;
			dpw = 1'b1;
			cyc(1);
			dpw = 1'b0;
			{v[2*s+1], v[2*s]} = dpd;
			i_core.rd(s ? ADDR_ALT_HIGH : ADDR_DATA_POINTER_HIGH, 1'b0, d);
			chk(d, dpd[15:8]);
			i_core.rd(s ? ADDR_DATA_POINTER_LOW : ADDR_ALT_LOW, 1'b0, d);
			chk(d, s ? v[0] : v[2]);
		end
		// bit access only at x0/x8
		foreach (v[i]) begin
			i_core.rd(8'h86 + 8'(i), 1'b0, d);
			chk(bok, (i == 2));
		end
		i_core.wr(ADDR_TIMER_CTRL, 8'h00);
		i_core.bwr(ADDR_TIMER_CTRL, 3'(TC_T0_RUN), 1'b1);
		i_core.bwr(ADDR_TIMER_MODE, 3'h0, 1'b1);
		i_core.rd(ADDR_TIMER_CTRL, 1'b0, d);
		chk(d, 8'h10);
		i_core.rd(ADDR_TIMER_MODE, 1'b0, d);
		chk(d, 8'h00);
		i_core.bwr(ADDR_STACK_PTR, 3'h0, ~t[0]);
		i_core.rd(ADDR_STACK_PTR, 1'b0, d);
		chk(d, t);
		i_core.bwr(ADDR_PORT0_DATA, 3'h3, 1'b0);
		i_core.wr(ADDR_PORT0_DIR, 8'hF7);
		i_core.rd(ADDR_PORT0_DATA, 1'b0, d);
		chk({d, oe}, {p0_exp(pin, 8'hF7, 8'hF7), 8'h08});
		i_core.wr(ADDR_PORT0_DIR, 8'hFF);
		// user flags; reserved bits ignored
		i_core.wr(ADDR_POWER_CTRL, 8'h0C);
		i_core.rd(ADDR_POWER_CTRL, 1'b0, d);
		chk(d & PC_IMPL_MASK, 8'h0C);
		// idle entry and interrupt exit, both wake types
		for (int i = 0; i < 2; i++) begin
			i_core.wr(ADDR_POWER_CTRL, {3'h0, 1'(i), 4'h1});
			@(negedge clk_sys_in);
			irq = 1'b1;
			#1;
			chk({16'(ps), cen, pen}, {16'(CSFR_PM_IDLE), 2'b01});
			@(negedge clk_sys_in);
			irq = 1'b0;
			#1;
			chk({16'(ps), wake, skip}, {16'(CSFR_PM_RUN), 1'b1, 1'(i)});
		end
		// power-down and three wake sources: external 2, ring and external 0 pin
		for (int j = 0; j < 3; j++) begin
			i_core.wr(ADDR_POWER_CTRL, 8'h02);
			@(negedge clk_sys_in);
			#1;
			chk({16'(ps), cen, pen}, {16'(CSFR_PM_DOWN), 2'b00});
			{i23, ring, xp} = (j == 0) ? 5'h0B : (j == 1) ? 5'h07 : 5'h02;
			cyc(1);
			{i23, ring, xp} = 5'h03;
			i_core.rd(ADDR_POWER_CTRL, 1'b0, d);
			chk({16'(ps), d & PC_IMPL_MASK}, {16'(CSFR_PM_RUN), 8'h00});
		end
		// overflow flags: hardware set, service clear, software set
		i_core.wr(ADDR_TIMER_CTRL, 8'h00);
		for (int i = 0; i < 2; i++) begin
			@(negedge clk_sys_in);
			ovf[i] = 1'b1;
			cyc(1);
			ovf = 2'h0;
			i_core.rd(ADDR_TIMER_CTRL, 1'b0, d);
			chk(d, 8'h20 << (2 * i));
			tack[i] = 1'b1;
			cyc(1);
			tack = 2'h0;
			i_core.rd(ADDR_TIMER_CTRL, 1'b0, d);
			chk(d, 8'h00);
		end
		i_core.wr(ADDR_TIMER_CTRL, 8'hA0);
		i_core.rd(ADDR_TIMER_CTRL, 1'b0, d);
		chk(d, 8'hA0);
		// external flags: edge latched and cleared on vector, level follows pin
		for (int x = 0; x < 2; x++) begin
			i_core.wr(ADDR_TIMER_CTRL, 8'h01 << (2 * x));
			@(negedge clk_sys_in);
			xp[x] = 1'b0;
			cyc(2);
			#1;
			chk(xf[x], 1'b1);
			xack[x] = 1'b1;
			cyc(1);
			{xack, xp} = 4'h3;
			cyc(2);
			#1;
			chk(xf[x], 1'b0);
			i_core.wr(ADDR_TIMER_CTRL, 8'h00);
			@(negedge clk_sys_in);
			xp[x] = 1'b0;
			cyc(2);
			#1;
			chk(xf[x], 1'b1);
			xp = 2'h3;
			cyc(2);
			#1;
			chk(xf[x], 1'b0);
		end
		// mode fields, every code in each half
		for (int i = 0; i < 4; i++) begin
			t = $urandom;
			t[1:0] = 2'(i);
			t[5:4] = ~2'(i);
			i_core.wr(ADDR_TIMER_MODE, t);
			i_core.rd(ADDR_TIMER_MODE, 1'b0, d);
			chk({d, mbad, tm}, {t, t[5:4] == 2'h3, t[1:0] == 2'h3, t[5:4], t[1:0]});
		end
		// gate, run and pin combinations on internal ticks
		for (int x = 0; x < 2; x++) begin
			for (int k = 0; k < 8; k++) begin
				i_core.wr(ADDR_TIMER_MODE, 8'(k & 1) << (4 * x + 3));
				i_core.wr(ADDR_TIMER_CTRL, 8'((k >> 1) & 1) << (4 + 2 * x));
				@(negedge clk_sys_in);
				xp[x] = k[2];
				tki = 2'h3;
				#1;
				chk(tk[x], tk_exp(k[0], k[1], k[2]));
			end
			{tki, xp} = 4'h3;
			// counter mode: one count per falling pin edge
			i_core.wr(ADDR_TIMER_MODE, 8'h04 << (4 * x));
			@(negedge clk_sys_in);
			tki = 2'h0;
			tp[x] = 1'b0;
			n = 0;
			repeat (3) begin
				#1;
				n += tk[x];
				@(negedge clk_sys_in);
			end
			tp = 2'h3;
			chk(16'(n), 16'h1);
		end
		close_out();
	end
endmodule : tb_top
